// ### rri_pkg.sv
// Purpose: Shared constants and types for reset register init and wake.
// Assumes: All register widths are eight bits except the program counter and the stack top.
// Notes:   The leaf gate module shares this file to keep two design files.
package rri_pkg;

  localparam int unsigned PC_W      = 21;
  localparam int unsigned REG_W     = 8;
  localparam int unsigned PTR_W     = 5;

  localparam logic [PC_W-1:0]  VEC_HIGH = 21'h000008;
  localparam logic [PC_W-1:0]  VEC_LOW  = 21'h000018;
  localparam logic [PC_W-1:0]  PC_ZERO  = 21'h000000;
  localparam logic [REG_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [PTR_W-1:0] PTR_ONE  = 5'h01;

  // Bit positions inside the reset-cause, stack-pointer, port and interrupt control registers.
  localparam int unsigned RC_IPEN   = 7;
  localparam int unsigned RC_RI     = 4;
  localparam int unsigned RC_TO     = 3;
  localparam int unsigned RC_PD     = 2;
  localparam int unsigned RC_POR    = 1;
  localparam int unsigned RC_BOR    = 0;
  localparam int unsigned SP_FULL   = 7;
  localparam int unsigned SP_UNDER  = 6;
  localparam int unsigned PA_BIT6   = 6;
  localparam int unsigned PG_BIT5   = 5;
  localparam int unsigned IRQ_EN_HIGH_BIT = 7;
  localparam int unsigned IRQ_EN_LOW_BIT  = 6;
  localparam logic [REG_W-1:0] IRQ_KEEP_MSK = 8'h01;

  // Reset values per reset class.
  localparam logic [REG_W-1:0] RC_POR_VAL  = 8'h1C;
  localparam logic [REG_W-1:0] IRQ_CTL_RST = 8'h00;
  localparam logic [REG_W-1:0] PIR_RST     = 8'h00;
  localparam logic [REG_W-1:0] PORT_RST    = 8'h00;
  localparam logic [REG_W-1:0] DIR_RST     = 8'hFF;
  localparam logic [REG_W-1:0] SP_FLAG_MSK = 8'hC0;
  localparam logic [REG_W-1:0] SP_IMPL_MSK = 8'hDF;

  // Oscillator modes; only two of them free port A bit 6 for I/O.
  typedef enum logic [2:0] {
    RRI_OSC_LP, RRI_OSC_XT, RRI_OSC_HS, RRI_OSC_HSPLL,
    RRI_OSC_EC, RRI_OSC_EXT_CLOCK_WITH_IO_MODE, RRI_OSC_RC, RRI_OSC_RC_OSC_WITH_IO_MODE
  } rri_osc_t;

  typedef enum logic [2:0] {
    RRI_SEL_TOS_U, RRI_SEL_TOS_H, RRI_SEL_TOS_L, RRI_SEL_SP,
    RRI_SEL_IRQ, RRI_SEL_PIR, RRI_SEL_RESET_CAUSE_CONTROL, RRI_SEL_MEM
  } rri_sel_a_t;

  typedef enum logic [1:0] {
    RRI_SEL_PA_PIN, RRI_SEL_PA_LAT, RRI_SEL_PA_DIR, RRI_SEL_PG_PIN
  } rri_sel_b_t;

  // Reset and wake events from the core, one-cycle pulses.
  typedef struct packed {
    logic por;
    logic bor;
    logic master_clear_pin;
    logic wdt_reset;
    logic reset_instr;
    logic stack_reset;
    logic wake_wdt;
    logic wake_irq;
    logic wake_irq_high;
  } rri_event_t;

  // Software register access, one register per cycle.
  typedef struct packed {
    logic             wr;
    logic             port_space;
    logic [2:0]       sel;
    logic [REG_W-1:0] data;
  } rri_access_t;

endpackage

`timescale 1ns/1ps

// Clears one bit of a register view unless it is implemented and enabled.
module rri_bit_gate
  import rri_pkg::*;
#(
  parameter int unsigned BIT = 0
) (
  // Data
  input  wire logic [REG_W-1:0] raw,
  input  wire logic             enable,
  output logic      [REG_W-1:0] gated
);
  always_comb begin
    gated      = raw;
    gated[BIT] = raw[BIT] & enable;
  end
endmodule

// ### rri_core.sv
// Purpose: Reset-class register initialisation and wake-up side effects.
// Assumes: Events arrive as single-cycle pulses on mclk; pins are async.
// Notes:   Reading happens through rd_data, one cycle after the request.
// How it works
// - Wake records its source in flag registers
// - Enabled interrupt wake loads vector 0008h/0018h
// - Same wake pushes current PC to stack top
// - Same wake advances the return stack pointer
// - Port A bit 6 lives only in I/O oscillator modes
// - Other oscillator modes read port A bit 6 zero
// - Variants without port A bit 6 read zero
// - Master clear disabled makes port G bit 5 read-only
// - Microcontroller mode hides memory control, reads zero
// - Unimplemented bits read zero; unchanged bits persist
// - Reset-cause bits follow the actual event
`timescale 1ns/1ps

module rri_core
  import rri_pkg::*;
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Core events and state
  input  wire rri_event_t       evt,
  input  wire logic [PC_W-1:0]  pc_cur,
  input  wire logic [REG_W-1:0] wake_flags,
  input  wire logic             wake_to_pir,
  // Configuration
  input  wire rri_osc_t         osc_mode,
  input  wire logic             has_port_a_bit6,
  input  wire logic             master_clear_pin_disabled,
  input  wire logic             micro_mode,
  // External pins
  input  wire logic [REG_W-1:0] first_port_pin_in,
  input  wire logic [REG_W-1:0] seventh_port_pin_in,
  // Software access
  input  wire rri_access_t      acc,
  output logic [REG_W-1:0]      rd_data,
  // Program counter
  output logic [PC_W-1:0]       pc_load_value,
  output logic                  pc_load
);

  logic [PC_W-1:0]  stack_top_reg;
  logic [REG_W-1:0] return_stack_pointer_reg;
  logic [REG_W-1:0] irq_control_regs_reg;
  logic [REG_W-1:0] peripheral_irq_flag_regs_reg;
  logic [REG_W-1:0] reset_cause_control_reg;
  logic [REG_W-1:0] ext_memory_control_reg;
  logic [REG_W-1:0] first_port_latch_reg;
  logic [REG_W-1:0] first_port_direction_reg;
  logic [REG_W-1:0] seventh_port_latch_reg;
  logic [REG_W-1:0] pa_meta_reg, pa_sync_reg;
  logic [REG_W-1:0] pg_meta_reg, pg_sync_reg;
  logic [REG_W-1:0] rd_data_next;
  logic [REG_W-1:0] pa_pin_view, pa_lat_view, pa_dir_view;
  logic             soft_reset;
  logic             full_reset;
  logic             irq_vectoring;
  logic             bit6_enable;
  logic             wr_a, wr_b;
  rri_sel_a_t       sel_a;
  rri_sel_b_t       sel_b;

  assign soft_reset = evt.master_clear_pin | evt.wdt_reset | evt.reset_instr
                    | evt.stack_reset;
  assign full_reset = evt.por | evt.bor;
  // Either global enable lets the wake vector and push the stack.
  assign irq_vectoring = evt.wake_irq
                       & (irq_control_regs_reg[IRQ_EN_HIGH_BIT]
                          | irq_control_regs_reg[IRQ_EN_LOW_BIT]);
  assign sel_a = rri_sel_a_t'(acc.sel);
  assign sel_b = rri_sel_b_t'(acc.sel[1:0]);
  assign wr_a  = acc.wr & ~acc.port_space;
  assign wr_b  = acc.wr & acc.port_space;

  assign bit6_enable = has_port_a_bit6
                     & ((osc_mode == RRI_OSC_EXT_CLOCK_WITH_IO_MODE)
                        | (osc_mode == RRI_OSC_RC_OSC_WITH_IO_MODE));

  // Port pins come from another domain; two flops before any use.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pa_meta_reg <= BYTE_ZERO;
      pa_sync_reg <= BYTE_ZERO;
      pg_meta_reg <= BYTE_ZERO;
      pg_sync_reg <= BYTE_ZERO;
    end else begin
      pa_meta_reg <= first_port_pin_in;
      pa_sync_reg <= pa_meta_reg;
      pg_meta_reg <= seventh_port_pin_in;
      pg_sync_reg <= pg_meta_reg;
    end
  end

  // Return stack top and pointer.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stack_top_reg            <= PC_ZERO;
      return_stack_pointer_reg <= BYTE_ZERO;
    end else if (full_reset) begin
      stack_top_reg            <= PC_ZERO;
      return_stack_pointer_reg <= BYTE_ZERO;
    end else if (soft_reset) begin
      stack_top_reg            <= PC_ZERO;
      // Overflow and underflow flags survive a soft reset.
      return_stack_pointer_reg <= return_stack_pointer_reg & SP_FLAG_MSK;
    end else if (irq_vectoring) begin
      stack_top_reg <= pc_cur;
      return_stack_pointer_reg[PTR_W-1:0] <=
        return_stack_pointer_reg[PTR_W-1:0] + PTR_ONE;
    end else if (wr_a && sel_a == RRI_SEL_SP) begin
      return_stack_pointer_reg <= acc.data & SP_IMPL_MSK;
    end
  end

  // Interrupt control and peripheral flags.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_control_regs_reg         <= IRQ_CTL_RST;
      peripheral_irq_flag_regs_reg <= PIR_RST;
    end else if (full_reset || soft_reset) begin
      // Bit 0 is unknown at power-on; it is kept rather than forced.
      irq_control_regs_reg <= irq_control_regs_reg & IRQ_KEEP_MSK;
      peripheral_irq_flag_regs_reg <= PIR_RST;
    end else begin
      // A wake source flag is ORed into a software write in the same cycle.
      if (wr_a && sel_a == RRI_SEL_IRQ) begin
        irq_control_regs_reg <= acc.data;
      end
      if (wr_a && sel_a == RRI_SEL_PIR) begin
        peripheral_irq_flag_regs_reg <= acc.data;
      end
      if ((evt.wake_wdt || evt.wake_irq) && !wake_to_pir) begin
        irq_control_regs_reg <= (wr_a && sel_a == RRI_SEL_IRQ ? acc.data
                                 : irq_control_regs_reg)
                                | wake_flags;
      end
      if ((evt.wake_wdt || evt.wake_irq) && wake_to_pir) begin
        peripheral_irq_flag_regs_reg <=
          (wr_a && sel_a == RRI_SEL_PIR ? acc.data
           : peripheral_irq_flag_regs_reg) | wake_flags;
      end
    end
  end

  // Reset-cause status bits reflect which event happened.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reset_cause_control_reg <= RC_POR_VAL;
    end else begin
      if (full_reset) begin
        reset_cause_control_reg <= RC_POR_VAL;
        reset_cause_control_reg[RC_POR] <= ~evt.por
                                         & reset_cause_control_reg[RC_POR];
        reset_cause_control_reg[RC_BOR] <= 1'b0;
      end else if (soft_reset) begin
        reset_cause_control_reg[RC_IPEN] <= 1'b0;
        reset_cause_control_reg[RC_RI] <= ~evt.reset_instr;
        reset_cause_control_reg[RC_TO] <= ~evt.wdt_reset;
        reset_cause_control_reg[RC_PD] <= ~evt.wdt_reset
                                        & reset_cause_control_reg[RC_PD];
      end else if (evt.wake_wdt || evt.wake_irq) begin
        reset_cause_control_reg[RC_RI] <= 1'b1;
        reset_cause_control_reg[RC_TO] <= ~evt.wake_wdt;
        reset_cause_control_reg[RC_PD] <= 1'b0;
      end else if (wr_a && sel_a == RRI_SEL_RESET_CAUSE_CONTROL) begin
        reset_cause_control_reg <= acc.data;
      end
    end
  end

  // Memory control and port latches.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ext_memory_control_reg   <= BYTE_ZERO;
      first_port_latch_reg     <= PORT_RST;
      first_port_direction_reg <= DIR_RST;
      seventh_port_latch_reg   <= PORT_RST;
    end else if (full_reset || soft_reset) begin
      ext_memory_control_reg   <= BYTE_ZERO;
      first_port_direction_reg <= DIR_RST;
    end else begin
      if (wr_a && sel_a == RRI_SEL_MEM && !micro_mode) begin
        ext_memory_control_reg <= acc.data;
      end
      if (wr_b && sel_b == RRI_SEL_PA_LAT) begin
        first_port_latch_reg <= acc.data;
      end
      if (wr_b && sel_b == RRI_SEL_PA_DIR) begin
        first_port_direction_reg <= acc.data;
      end
      if (wr_b && sel_b == RRI_SEL_PG_PIN) begin
        seventh_port_latch_reg <= acc.data;
        if (master_clear_pin_disabled) begin
          seventh_port_latch_reg[PG_BIT5] <=
            seventh_port_latch_reg[PG_BIT5];
        end
      end
    end
  end

  rri_bit_gate #(.BIT(PA_BIT6)) u_gate_pin (
    .raw    (pa_sync_reg),
    .enable (bit6_enable),
    .gated  (pa_pin_view)
  );
  rri_bit_gate #(.BIT(PA_BIT6)) u_gate_lat (
    .raw    (first_port_latch_reg),
    .enable (bit6_enable),
    .gated  (pa_lat_view)
  );
  rri_bit_gate #(.BIT(PA_BIT6)) u_gate_dir (
    .raw    (first_port_direction_reg),
    .enable (bit6_enable),
    .gated  (pa_dir_view)
  );

  always_comb begin
    rd_data_next = BYTE_ZERO;
    if (acc.port_space) begin
      case (sel_b)
        RRI_SEL_PA_PIN: rd_data_next = pa_pin_view;
        RRI_SEL_PA_LAT: rd_data_next = pa_lat_view;
        RRI_SEL_PA_DIR: rd_data_next = pa_dir_view;
        RRI_SEL_PG_PIN: begin
          // Bit 5 reads its store, so a refused write leaves the old value visible.
          rd_data_next          = pg_sync_reg;
          rd_data_next[PG_BIT5] = seventh_port_latch_reg[PG_BIT5];
        end
        default:        rd_data_next = BYTE_ZERO;
      endcase
    end else begin
      case (sel_a)
        RRI_SEL_TOS_U: rd_data_next = {3'h0, stack_top_reg[20:16]};
        RRI_SEL_TOS_H: rd_data_next = stack_top_reg[15:8];
        RRI_SEL_TOS_L: rd_data_next = stack_top_reg[7:0];
        RRI_SEL_SP:    rd_data_next = return_stack_pointer_reg;
        RRI_SEL_IRQ:   rd_data_next = irq_control_regs_reg;
        RRI_SEL_PIR:   rd_data_next = peripheral_irq_flag_regs_reg;
        RRI_SEL_RESET_CAUSE_CONTROL:  rd_data_next = reset_cause_control_reg;
        RRI_SEL_MEM:   rd_data_next = micro_mode ? BYTE_ZERO
                                      : ext_memory_control_reg;
        default:       rd_data_next = BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_data <= BYTE_ZERO;
    end else begin
      rd_data <= rd_data_next;
    end
  end

  // Program counter load: zero for resets, vector for enabled irq wake.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc_load       <= 1'b0;
      pc_load_value <= PC_ZERO;
    end else begin
      pc_load <= full_reset | soft_reset | irq_vectoring;
      if (full_reset || soft_reset) begin
        pc_load_value <= PC_ZERO;
      end else if (irq_vectoring) begin
        pc_load_value <= evt.wake_irq_high ? VEC_HIGH : VEC_LOW;
      end
    end
  end

endmodule

// ### rri_core_monitor.sv
// Purpose: Port-level checks for the reset-init and wake block.
// Assumes: rd_data answers the access select one cycle later.
// Notes:   Global enables are internal, so wake checks run one way.
`timescale 1ns/1ps

module rri_core_monitor
  import rri_pkg::*;
(
  // Clock and reset
  input wire logic             mclk,
  input wire logic             rst,
  // Inputs
  input wire rri_event_t       evt,
  input wire rri_osc_t         osc_mode,
  input wire logic             has_port_a_bit6,
  input wire logic             micro_mode,
  input wire rri_access_t      acc,
  // Outputs
  input wire logic [REG_W-1:0] rd_data,
  input wire logic [PC_W-1:0]  pc_load_value,
  input wire logic             pc_load
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic pa_sel;
  logic core_sel;
  logic evt_reset;
  assign pa_sel = acc.port_space && (acc.sel[1:0] != RRI_SEL_PG_PIN);
  assign core_sel = !acc.port_space;
  // Any reset class loads a zero program counter, not a vector.
  assign evt_reset = evt.por | evt.bor | evt.master_clear_pin | evt.wdt_reset
                   | evt.reset_instr | evt.stack_reset;

  AST_LOAD_CAUSE: assert property (
    pc_load |-> $past(evt.wake_irq || evt_reset))
    else $error("program counter load without wake or reset");
  AST_VEC_SEL: assert property (pc_load && !$past(evt_reset) |->
    pc_load_value == ($past(evt.wake_irq_high) ? VEC_HIGH : VEC_LOW))
    else $error("wrong wake vector");
  AST_RESET_LOAD: assert property (
    evt_reset |=> pc_load && pc_load_value == PC_ZERO)
    else $error("reset did not load a zero program counter");
  AST_VEC_HOLD: assert property (!pc_load |-> $stable(pc_load_value))
    else $error("vector changed without load");
  AST_WDT_NO_LOAD: assert property (
    evt.wake_wdt && !evt.wake_irq && !evt_reset |=> !pc_load)
    else $error("watchdog wake loaded a vector");
  AST_MEM_ZERO: assert property (
    core_sel && acc.sel == RRI_SEL_MEM && micro_mode |=> rd_data == 8'h00)
    else $error("memory control visible in microcontroller mode");
  AST_PA6_OSC: assert property (pa_sel &&
    !(osc_mode inside {RRI_OSC_EXT_CLOCK_WITH_IO_MODE, RRI_OSC_RC_OSC_WITH_IO_MODE}) |=> !rd_data[6])
    else $error("port A bit 6 set outside I/O oscillator modes");
  AST_PA6_VAR: assert property (
    pa_sel && !has_port_a_bit6 |=> !rd_data[6])
    else $error("port A bit 6 set on variant without it");
  AST_SP_GAP: assert property (
    core_sel && acc.sel == RRI_SEL_SP |=> rd_data[5] == 1'b0)
    else $error("stack pointer bit 5 not zero");
  AST_STACK_TOP_UPPER_GAP: assert property (
    core_sel && acc.sel == RRI_SEL_TOS_U |=> rd_data[7:5] == 3'h0)
    else $error("stack top upper gap bits not zero");

  cover property (pc_load && pc_load_value == 21'h000008);
  cover property (pc_load && pc_load_value == 21'h000018);
  cover property (core_sel && acc.sel == RRI_SEL_MEM && micro_mode);
endmodule

bind rri_core rri_core_monitor u_rri_core_monitor (
  .mclk(mclk), .rst(rst), .evt(evt), .osc_mode(osc_mode),
  .has_port_a_bit6(has_port_a_bit6), .micro_mode(micro_mode), .acc(acc),
  .rd_data(rd_data), .pc_load_value(pc_load_value), .pc_load(pc_load));

// ### rri_core_tb_top.sv
// Purpose: Self-checking bench for the reset-init and wake block.
// Assumes: Inputs change 1 ns after the rising edge of mclk.
// Notes:   Port pin and direction reads use a table; latch reads, wakes and resets are written out.
`timescale 1ns/1ps

module rri_core_tb_top
  import rri_pkg::*;
;
  typedef struct packed {
    rri_osc_t         osc;
    logic             b6;
    logic [1:0]       sel;
    logic [REG_W-1:0] exp;
  } rri_row_t;

  logic             mclk = 1'b0;
  logic             rst = 1'b1;
  rri_event_t       evt = '0;
  logic [PC_W-1:0]  pc_cur = '0;
  logic [REG_W-1:0] wake_flags = 8'h04;
  logic             wake_to_pir = 1'b1;
  rri_osc_t         osc_mode = RRI_OSC_EXT_CLOCK_WITH_IO_MODE;
  logic             has_port_a_bit6 = 1'b1;
  logic             master_clear_pin_disabled = 1'b1;
  logic             micro_mode = 1'b0;
  logic [REG_W-1:0] pa_pins = 8'hFF;
  logic [REG_W-1:0] pg_pins = 8'h5A;
  rri_access_t      acc = '0;
  logic [REG_W-1:0] rd_data;
  logic [PC_W-1:0]  pc_load_value;
  logic             pc_load;
  int               error_cnt = 0;
  int               tests_run = 0;
  rri_row_t         rows [12];

  always #2.5 mclk = ~mclk;

  rri_core u_rri_core (
    .mclk(mclk), .rst(rst), .evt(evt), .pc_cur(pc_cur),
    .wake_flags(wake_flags), .wake_to_pir(wake_to_pir),
    .osc_mode(osc_mode), .has_port_a_bit6(has_port_a_bit6),
    .master_clear_pin_disabled(master_clear_pin_disabled), .micro_mode(micro_mode),
    .first_port_pin_in(pa_pins), .seventh_port_pin_in(pg_pins),
    .acc(acc), .rd_data(rd_data), .pc_load_value(pc_load_value),
    .pc_load(pc_load));

  task automatic check(string what, logic [PC_W-1:0] seen,
                       logic [PC_W-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic acc_op(logic w, logic ps, logic [2:0] s, logic [7:0] d);
    @(posedge mclk);
    #1 acc = '{w, ps, s, d};
    @(posedge mclk);
    #1 acc.wr = 1'b0;
  endtask

  // Reads a core register and compares only the bits in the mask.
  task automatic rd(string n, logic [2:0] s, logic [7:0] e, logic [7:0] m);
    acc_op(1'b0, 1'b0, s, 8'h00);
    check(n, PC_W'(rd_data & m), PC_W'(e));
  endtask

  // Event bits from por down to wake_irq_high, one-cycle pulse.
  task automatic pulse(rri_event_t e);
    @(posedge mclk);
    #1 evt = e;
    @(posedge mclk);
    #1 evt = '0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #5000;
    error_cnt++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial begin
    for (int i = 0; i < 8; i++) begin
      rows[i] = '{rri_osc_t'(i), 1'b1, 2'h0,
                  (rri_osc_t'(i) inside {RRI_OSC_EXT_CLOCK_WITH_IO_MODE, RRI_OSC_RC_OSC_WITH_IO_MODE}) ?
                  8'hFF : 8'hBF};
    end
    rows[8] = '{RRI_OSC_LP, 1'b1, 2'h2, 8'hBF};
    rows[9] = '{RRI_OSC_RC_OSC_WITH_IO_MODE, 1'b1, 2'h2, 8'hFF};
    rows[10] = '{RRI_OSC_EXT_CLOCK_WITH_IO_MODE, 1'b0, 2'h0, 8'hBF};
    rows[11] = '{RRI_OSC_LP, 1'b1, 2'h3, 8'h5A};
    repeat (5) @(posedge mclk);
    #1 rst = 1'b0;
    rd("reset_cause_control", RRI_SEL_RESET_CAUSE_CONTROL, 8'h1C, 8'hFF);
    rd("sp", RRI_SEL_SP, 8'h00, 8'hFF);
    rd("stack_top_low", RRI_SEL_TOS_L, 8'h00, 8'hFF);
    rd("irq", RRI_SEL_IRQ, 8'h00, 8'hFE);
    $display("test reset values done");
    for (int i = 0; i < 12; i++) begin
      osc_mode = rows[i].osc;
      has_port_a_bit6 = rows[i].b6;
      acc_op(1'b0, 1'b1, {1'b0, rows[i].sel}, 8'h00);
      check("port", PC_W'(rd_data), PC_W'(rows[i].exp));
    end
    $display("test port table done");
    acc_op(1'b1, 1'b1, 3'h1, 8'hFF);
    acc_op(1'b0, 1'b1, 3'h1, 8'h00);
    check("pa_lat", PC_W'(rd_data), PC_W'(8'hBF));
    osc_mode = RRI_OSC_EXT_CLOCK_WITH_IO_MODE;
    acc_op(1'b0, 1'b1, 3'h1, 8'h00);
    check("pa_lat", PC_W'(rd_data), PC_W'(8'hFF));
    acc_op(1'b1, 1'b1, 3'h3, 8'h20);
    acc_op(1'b0, 1'b1, 3'h3, 8'h00);
    check("pg", PC_W'(rd_data), PC_W'(8'h5A));
    master_clear_pin_disabled = 1'b0;
    acc_op(1'b1, 1'b1, 3'h3, 8'h20);
    acc_op(1'b0, 1'b1, 3'h3, 8'h00);
    check("pg", PC_W'(rd_data), PC_W'(8'h7A));
    $display("test port bits done");
    micro_mode = 1'b1;
    acc_op(1'b1, 1'b0, RRI_SEL_MEM, 8'hFF);
    rd("mem", RRI_SEL_MEM, 8'h00, 8'hFF);
    micro_mode = 1'b0;
    rd("mem", RRI_SEL_MEM, 8'h00, 8'hFF);
    acc_op(1'b1, 1'b0, RRI_SEL_MEM, 8'h55);
    rd("mem", RRI_SEL_MEM, 8'h55, 8'hFF);
    $display("test memory control done");
    acc_op(1'b1, 1'b0, RRI_SEL_IRQ, 8'h81);
    pc_cur = 21'h12345;
    pulse(9'h003);
    check("load", PC_W'(pc_load), 21'h1);
    check("vector", pc_load_value, 21'h000008);
    rd("stack_top_upper", RRI_SEL_TOS_U, 8'h01, 8'hFF);
    rd("stack_top_high", RRI_SEL_TOS_H, 8'h23, 8'hFF);
    rd("stack_top_low", RRI_SEL_TOS_L, 8'h45, 8'hFF);
    rd("sp", RRI_SEL_SP, 8'h01, 8'h1F);
    rd("pir", RRI_SEL_PIR, 8'h04, 8'hFF);
    pc_cur = 21'h00ABC;
    pulse(9'h002);
    check("vector", pc_load_value, 21'h000018);
    rd("stack_top_low", RRI_SEL_TOS_L, 8'hBC, 8'hFF);
    rd("sp", RRI_SEL_SP, 8'h02, 8'h1F);
    pulse(9'h004);
    check("load", PC_W'(pc_load), 21'h0);
    acc_op(1'b1, 1'b0, RRI_SEL_IRQ, 8'h01);
    pulse(9'h003);
    check("load", PC_W'(pc_load), 21'h0);
    rd("sp", RRI_SEL_SP, 8'h02, 8'h1F);
    wake_to_pir = 1'b0;
    pulse(9'h004);
    rd("irq", RRI_SEL_IRQ, 8'h05, 8'hFF);
    rd("reset_cause_control", RRI_SEL_RESET_CAUSE_CONTROL, 8'h10, 8'h1C);
    $display("test wake done");
    pulse(9'h040);
    rd("sp", RRI_SEL_SP, 8'h00, 8'hFF);
    rd("stack_top_low", RRI_SEL_TOS_L, 8'h00, 8'hFF);
    rd("irq", RRI_SEL_IRQ, 8'h01, 8'hFF);
    acc_op(1'b1, 1'b0, RRI_SEL_RESET_CAUSE_CONTROL, 8'h03);
    pulse(9'h080);
    rd("reset_cause_control", RRI_SEL_RESET_CAUSE_CONTROL, 8'h02, 8'h03);
    pulse(9'h100);
    rd("reset_cause_control", RRI_SEL_RESET_CAUSE_CONTROL, 8'h1C, 8'h1F);
    $display("test soft resets done");
    tally_and_finish();
  end
endmodule
